// [rtl/fbp_pkg.sv]
// shared constants and types for the flash burst and program block
package fbp_pkg;
  localparam int DATA_W = 16;
  localparam int CMD_W  = 8;
  // read configuration layout
  localparam logic [15:0] RCFG_RESET = 16'hFFC7;
  localparam logic [15:0] RCFG_RSV_MASK = 16'h0038;
  localparam int RM_POS    = 15;
  localparam int LAT_LO    = 11;
  localparam int WPOL_POS  = 10;
  localparam int HOLD_POS  = 9;
  localparam int WDLY_POS  = 8;
  localparam int ORDER_POS = 7;
  localparam int EDGE_POS  = 6;
  localparam int BL_LO     = 0;
  localparam logic [3:0] LAT_MIN = 4'h2;
  localparam logic [3:0] LAT_MAX = 4'hA;
  localparam logic [2:0] BL_8    = 3'h2;
  localparam logic [2:0] BL_16   = 3'h3;
  localparam logic [3:0] WRAP8_MASK  = 4'h7;
  localparam logic [3:0] WRAP16_MASK = 4'hF;
  // commands on the low data byte
  localparam logic [7:0] CMD_WORD_A    = 8'h40;
  localparam logic [7:0] CMD_WORD_B    = 8'h10;
  localparam logic [7:0] CMD_BUF_SETUP = 8'hE8;
  localparam logic [7:0] CMD_CONFIRM   = 8'hD0;
  localparam logic [7:0] CMD_CLR_STAT  = 8'h50;
  // write buffer
  localparam int BUF_WORDS = 32;
  localparam int SLOT_W    = 5;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  typedef enum logic [2:0] {
    P_IDLE    = 3'b000,
    P_WDATA   = 3'b001,
    P_WPROG   = 3'b010,
    P_WCOUNT  = 3'b011,
    P_FILL    = 3'b100,
    P_CONFIRM = 3'b101,
    P_BPROG   = 3'b110
  } fbp_prog_state_t;
  typedef enum logic [1:0] {
    B_IDLE = 2'b00,
    B_LAT  = 2'b01,
    B_DATA = 2'b10
  } fbp_burst_state_t;
endpackage

// [rtl/fbp_rd_if.sv]
// burst read link between the core and its burst engine
`timescale 1ns/1ps
`default_nettype none
interface fbp_rd_if #(parameter int ADDR_W = 17);
  logic                       burstMode;
  logic [3:0]                 latency;
  logic                       waitPol;
  logic                       holdTwo;
  logic                       waitEarly;
  logic                       risingEdge;
  logic                       len16;
  logic [ADDR_W-1:0]          rdAddr;
  logic [fbp_pkg::DATA_W-1:0] rdData;
  logic [fbp_pkg::DATA_W-1:0] dataOut;
  logic                       dataOe;
  logic                       waitOut;
  modport eng (input burstMode, latency, waitPol, holdTwo, waitEarly,
               input risingEdge, len16, rdData,
               output rdAddr, dataOut, dataOe, waitOut);
  modport core (output burstMode, latency, waitPol, holdTwo, waitEarly,
                output risingEdge, len16, rdData,
                input rdAddr, dataOut, dataOe, waitOut);
endinterface
`default_nettype wire

// [rtl/fbp_burst_engine.sv]
// synchronous burst read sequencer: latency, wait, hold and wrap
`timescale 1ns/1ps
`default_nettype none
module fbp_burst_engine #(
  parameter int ADDR_W = 17
) (
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              flashClkS,
  input  wire logic              advNS,
  input  wire logic              ceNS,
  input  wire logic [ADDR_W-1:0] addrS,
  fbp_rd_if.eng                  bus
);
  import fbp_pkg::*;

  fbp_burst_state_t  state;
  logic              clkPrev;
  logic              advPrev;
  logic [ADDR_W-1:0] base;
  logic [3:0]        idx;
  logic [3:0]        cnt;
  logic              holdPh;
  logic              rise;
  logic              fall;
  logic              actEdge;
  logic              latchNow;
  logic [3:0]        mask;
  logic [3:0]        rdIdx;

  function automatic logic [3:0] wrapLow(input logic [3:0] start,
                                         input logic [3:0] off,
                                         input logic [3:0] m);
    wrapLow = (start & ~m) | (4'(start + off) & m);
  endfunction

  assign rise    = flashClkS & ~clkPrev;
  assign fall    = ~flashClkS & clkPrev;
  assign actEdge = bus.risingEdge ? rise : fall; // R8
  // ADV rising edge, or an active edge while ADV is low, latches; only the
  // first of the two counts, a later ADV rise must not restart the burst
  assign latchNow = ~ceNS & bus.burstMode & (state == B_IDLE) &
                    ((advNS & ~advPrev) | (actEdge & ~advNS)); // R24 R23
  assign mask  = bus.len16 ? WRAP16_MASK : WRAP8_MASK; // R9
  assign rdIdx = (state == B_DATA) ? 4'(idx + 4'h1) : idx;
  assign bus.rdAddr = {base[ADDR_W-1:4], wrapLow(base[3:0], rdIdx, mask)}; // R7 R6

  always_ff @(posedge mclk) begin
    if (srst) begin
      clkPrev <= 1'b0;
      advPrev <= 1'b1;
    end else begin
      clkPrev <= flashClkS;
      advPrev <= advNS;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state       <= B_IDLE;
      base        <= '0;
      idx         <= 4'h0;
      cnt         <= 4'h0;
      holdPh      <= 1'b0;
      bus.dataOut <= '0;
      bus.dataOe  <= 1'b0;
      bus.waitOut <= 1'b0;
    end else if (ceNS || !bus.burstMode) begin
      state       <= B_IDLE;
      bus.dataOe  <= 1'b0;
      bus.waitOut <= ~bus.waitPol; // R3
    end else if (latchNow) begin
      state       <= B_LAT;
      base        <= addrS;
      idx         <= 4'h0;
      cnt         <= 4'h0;
      holdPh      <= 1'b0;
      bus.dataOe  <= 1'b0;
      bus.waitOut <= bus.waitPol; // R25 R3
    end else if (actEdge) begin
      case (state)
        B_LAT: begin
          cnt <= 4'(cnt + 4'h1);
          if (4'(cnt + 4'h1) == bus.latency) begin
            state       <= B_DATA; // R1
            bus.dataOut <= bus.rdData;
            bus.dataOe  <= 1'b1;
            bus.waitOut <= ~bus.waitPol; // R5
          end else if (bus.waitEarly && 4'(cnt + 4'h2) == bus.latency) begin
            bus.waitOut <= ~bus.waitPol; // R5
          end
        end
        B_DATA: begin
          // a second edge on the same word when holding for two clocks
          if (bus.holdTwo && !holdPh) begin
            holdPh <= 1'b1; // R4
          end else begin
            holdPh      <= 1'b0;
            idx         <= 4'(idx + 4'h1);
            bus.dataOut <= bus.rdData; // R7
          end
        end
        default: state <= B_IDLE;
      endcase
    end else if (state == B_IDLE) begin
      bus.waitOut <= ~bus.waitPol;
    end
  end

  logic idleStay;
  assign idleStay = (state == B_IDLE) && !latchNow;

  a_idle_wait_level: assert property (@(posedge mclk) disable iff (srst) // R3
    $past(idleStay) && $stable(bus.waitPol) && !$past(srst)
      |-> bus.waitOut == !bus.waitPol)
    else $error("wait not released level while idle");
  a_first_data_lat: assert property (@(posedge mclk) disable iff (srst) // R1
    (state == B_DATA) && $past(state) == B_LAT
      |-> $past(cnt) + 4'h1 == bus.latency && bus.dataOe)
    else $error("first word not at latency count");
  a_wait_released: assert property (@(posedge mclk) disable iff (srst) // R5
    $rose(bus.dataOe) && !bus.waitEarly && $stable(bus.waitPol)
      |-> $past(bus.waitOut) == bus.waitPol && bus.waitOut == !bus.waitPol)
    else $error("wait not released with valid data");
  a_hold_two_edges: assert property (@(posedge mclk) disable iff (srst) // R4
    (state == B_DATA) && actEdge && bus.holdTwo && !holdPh && !latchNow
      && !ceNS && bus.burstMode |=> $stable(idx) && holdPh)
    else $error("word not held for two clocks");
  a_wrap_group: assert property (@(posedge mclk) disable iff (srst) // R7
    state != B_IDLE |-> bus.rdAddr[ADDR_W-1:4] == base[ADDR_W-1:4]
      && (bus.rdAddr[3:0] & ~mask) == (base[3:0] & ~mask))
    else $error("burst address left its wrap group");
endmodule
`default_nettype wire

// [rtl/fbp_flash_core.sv]
// flash core: read configuration, word and buffered programming, array
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: first burst word after latency count edges
// R2: host picks latency fitting its clock
// R3: wait polarity bit chooses active level
// R4: hold bit keeps each word two clocks
// R5: delay bit releases wait one clock early
// R6: only linear burst order accepted
// R7: ascending words wrapping in 8 or 16
// R8: clock edge bit picks launch edge
// R9: length field selects 8 or 16 words
// R10: locked block program aborts, sets lock/program
// R11: host unlocks locked-down block first
// R12: word finishes before standby is entered
// R13: programming only clears bits, AND with old
// R14: fail, supply and lock flags after program
// R15: 32-word buffer mapped by low address bits
// R16: buffer setup, ready flag shows buffer free
// R17: host skips status command during sequence
// R18: host writes count minus one, then data
// R19: confirm starts copy, else sequence error
// R20: array failure stops, sets program/ready flags
// R21: both errors block setup; crossing aborts
// R22: latency codes two to ten only
// R23: read mode zero selects burst reads
// R24: address latched by ADV rise or edge
// R25: wait held from latch until latency
module fbp_flash_core #(
  parameter int ADDR_W      = 17,
  parameter int BLK_W       = 16,
  parameter int PROG_CYCLES = 16
) (
  input  wire logic                         mclk,
  input  wire logic                         srst,
  input  wire logic                         flashClk,
  input  wire logic                         advN,
  input  wire logic                         ceN,
  input  wire logic [ADDR_W-1:0]            addrPin,
  input  wire logic                         supplyPin,
  output logic [fbp_pkg::DATA_W-1:0]        burstData,
  output logic                              burstOe,
  output logic                              waitPin,
  input  wire logic                         cfgLoad,
  input  wire logic [fbp_pkg::DATA_W-1:0]   cfgValue,
  output logic [fbp_pkg::DATA_W-1:0]        readConfiguration,
  input  wire logic                         hostWr,
  input  wire logic [ADDR_W-1:0]            hostAddr,
  input  wire logic [fbp_pkg::DATA_W-1:0]   hostData,
  input  wire logic [(1<<(ADDR_W-BLK_W))-1:0] blockLocked,
  input  wire logic                         progFault,
  output logic                              machineReadyFlag,
  output logic                              sequenceErrorFlag,
  output logic                              programErrorFlag,
  output logic                              supplyFaultFlag,
  output logic                              lockErrorFlag,
  output logic                              standby
);
  import fbp_pkg::*;

  localparam int NBLK  = 1 << (ADDR_W - BLK_W);
  localparam int TIM_W = $clog2(2 * PROG_CYCLES + 1);
  localparam logic [TIM_W-1:0] WORD_T = TIM_W'(PROG_CYCLES - 1);
  localparam logic [TIM_W-1:0] SLOW_T = TIM_W'(2 * PROG_CYCLES - 1);
  localparam int SYNC_W = ADDR_W + 4;

  fbp_rd_if #(.ADDR_W(ADDR_W)) rd ();

  // pin synchroniser; only stage B is read by logic
  logic [SYNC_W-1:0] syncA;
  logic [SYNC_W-1:0] syncB;
  logic              flashClkS;
  logic              advNS;
  logic              ceNS;
  logic              supplyOk;
  logic [ADDR_W-1:0] addrS;

  always_ff @(posedge mclk) begin
    if (srst) begin
      syncA <= {4'h6, {ADDR_W{1'b0}}};
      syncB <= {4'h6, {ADDR_W{1'b0}}};
    end else begin
      syncA <= {flashClk, advN, ceN, supplyPin, addrPin};
      syncB <= syncA;
    end
  end
  assign {flashClkS, advNS, ceNS, supplyOk, addrS} = syncB;

  // read configuration
  logic [DATA_W-1:0] rcfg_reg;
  logic              cfgOk;
  logic [3:0]        cfgLat;
  logic [2:0]        cfgLen;

  assign cfgLat = cfgValue[LAT_LO+:4];
  assign cfgLen = cfgValue[BL_LO+:3];
  // async mode may carry any field; burst mode needs a legal shape
  assign cfgOk = cfgValue[RM_POS] ||
                 (cfgLat >= LAT_MIN && cfgLat <= LAT_MAX && // R22
                  (cfgLen == BL_8 || cfgLen == BL_16) && // R9
                  cfgValue[ORDER_POS]); // R6

  always_ff @(posedge mclk) begin
    if (srst) begin
      rcfg_reg <= RCFG_RESET; // R23
    end else if (cfgLoad && cfgOk) begin
      rcfg_reg <= cfgValue & ~RCFG_RSV_MASK;
    end
  end

  assign rd.burstMode  = ~rcfg_reg[RM_POS]; // R23
  assign rd.latency    = rcfg_reg[LAT_LO+:4];
  assign rd.waitPol    = rcfg_reg[WPOL_POS];
  assign rd.holdTwo    = rcfg_reg[HOLD_POS];
  assign rd.waitEarly  = rcfg_reg[WDLY_POS];
  assign rd.risingEdge = rcfg_reg[EDGE_POS];
  assign rd.len16      = rcfg_reg[BL_LO+:3] == BL_16;

  fbp_burst_engine #(.ADDR_W(ADDR_W)) engine (
    .mclk      (mclk),
    .srst      (srst),
    .flashClkS (flashClkS),
    .advNS     (advNS),
    .ceNS      (ceNS),
    .addrS     (addrS),
    .bus       (rd)
  );

  // array; erased contents at start
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  initial begin
    for (int k = 0; k < (1 << ADDR_W); k++) begin
      mem[k] = ERASED_WORD;
    end
  end
  assign rd.rdData = mem[rd.rdAddr];

  function automatic logic [ADDR_W-BLK_W-1:0] blockOf(
    input logic [ADDR_W-1:0] a);
    blockOf = a[ADDR_W-1:BLK_W];
  endfunction

  // program sequencing
  fbp_prog_state_t   pst;
  logic [TIM_W-1:0]  timer;
  logic [SLOT_W-1:0] cntReg;
  logic [SLOT_W:0]   left;
  logic [SLOT_W-1:0] idx;
  logic [ADDR_W-1:0] blkAddr;
  logic [ADDR_W-1:0] startAddr;
  logic [ADDR_W-1:0] progAddr;
  logic [DATA_W-1:0] progData;
  logic              firstWord;
  logic              ready_reg;
  logic [DATA_W-1:0] bufMem [0:BUF_WORDS-1];
  logic [BUF_WORDS-1:0] bufValid;
  logic [CMD_W-1:0]  cmd;
  logic [ADDR_W-1:0] firstEnd;
  logic              fillBad;
  logic              wordDone;
  logic              lockedHost;
  logic              lockedBlk;
  logic [DATA_W-1:0] newWord;
  logic              setLock;
  logic              setProg;
  logic              setSeq;
  logic              setSup;
  logic              clrStat;

  assign cmd        = hostData[CMD_W-1:0];
  assign lockedHost = blockLocked[blockOf(hostAddr)];
  assign lockedBlk  = blockLocked[blockOf(blkAddr)];
  assign firstEnd   = hostAddr + ADDR_W'(cntReg);
  // the counted range must sit in the setup block and inside the range
  assign fillBad = firstWord ?
      (blockOf(firstEnd) != blockOf(blkAddr) || firstEnd < hostAddr ||
       blockOf(hostAddr) != blockOf(blkAddr)) :
      (hostAddr < startAddr || hostAddr > startAddr + ADDR_W'(cntReg));
  assign wordDone = (pst == P_WPROG || pst == P_BPROG) && timer == '0;
  assign newWord  = (pst == P_WPROG) ? progData :
                    (bufValid[progAddr[SLOT_W-1:0]] ?
                     bufMem[progAddr[SLOT_W-1:0]] : ERASED_WORD);

  always_comb begin
    setLock = 1'b0;
    setProg = 1'b0;
    setSeq  = 1'b0;
    setSup  = 1'b0;
    clrStat = 1'b0;
    case (pst)
      P_IDLE: clrStat = hostWr && cmd == CMD_CLR_STAT;
      P_WDATA: begin
        if (hostWr && lockedHost) begin
          setLock = 1'b1; // R10
          setProg = 1'b1;
        end else if (hostWr && !supplyOk) begin
          setSup  = 1'b1; // R14
          setProg = 1'b1;
        end
      end
      P_FILL: begin
        if (hostWr && fillBad) begin
          setSeq  = 1'b1; // R21
          setProg = 1'b1;
        end
      end
      P_CONFIRM: begin
        if (hostWr && cmd != CMD_CONFIRM) begin
          setSeq  = 1'b1; // R19
          setProg = 1'b1;
        end else if (hostWr && lockedBlk) begin
          setLock = 1'b1; // R10
          setProg = 1'b1;
        end else if (hostWr && !supplyOk) begin
          setSup  = 1'b1; // R14
          setProg = 1'b1;
        end
      end
      P_WPROG, P_BPROG: setProg = wordDone && progFault; // R14 R20
      default: ;
    endcase
  end

  // status flags: a set in the cycle of a clear survives
  always_ff @(posedge mclk) begin
    if (srst) begin
      lockErrorFlag     <= 1'b0;
      programErrorFlag  <= 1'b0;
      sequenceErrorFlag <= 1'b0;
      supplyFaultFlag   <= 1'b0;
    end else begin
      lockErrorFlag     <= (lockErrorFlag & ~clrStat) | setLock;
      programErrorFlag  <= (programErrorFlag & ~clrStat) | setProg;
      sequenceErrorFlag <= (sequenceErrorFlag & ~clrStat) | setSeq;
      supplyFaultFlag   <= (supplyFaultFlag & ~clrStat) | setSup;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pst       <= P_IDLE;
      ready_reg <= 1'b1;
      timer     <= '0;
      cntReg    <= '0;
      left      <= '0;
      idx       <= '0;
      blkAddr   <= '0;
      startAddr <= '0;
      progAddr  <= '0;
      progData  <= '0;
      firstWord <= 1'b0;
    end else begin
      case (pst)
        P_IDLE: begin
          if (hostWr && (cmd == CMD_WORD_A || cmd == CMD_WORD_B)) begin
            pst <= P_WDATA;
          end else if (hostWr && cmd == CMD_BUF_SETUP &&
                       !(programErrorFlag && sequenceErrorFlag)) begin
            pst     <= P_WCOUNT; // R16 R21
            blkAddr <= hostAddr;
          end
        end
        P_WDATA: begin
          if (hostWr && (lockedHost || !supplyOk)) begin
            pst <= P_IDLE; // R10
          end else if (hostWr) begin
            progAddr  <= hostAddr; // R12
            progData  <= hostData;
            timer     <= WORD_T;
            ready_reg <= 1'b0;
            pst       <= P_WPROG;
          end
        end
        P_WCOUNT: begin
          if (hostWr) begin
            cntReg    <= hostData[SLOT_W-1:0]; // R18
            left      <= {1'b0, hostData[SLOT_W-1:0]};
            firstWord <= 1'b1;
            pst       <= P_FILL;
          end
        end
        P_FILL: begin
          if (hostWr && fillBad) begin
            pst <= P_IDLE; // R21
          end else if (hostWr) begin
            if (firstWord) begin
              startAddr <= hostAddr;
            end
            firstWord <= 1'b0;
            if (left == '0) begin
              pst <= P_CONFIRM;
            end else begin
              left <= left - 1'b1;
            end
          end
        end
        P_CONFIRM: begin
          if (hostWr && cmd == CMD_CONFIRM && !lockedBlk && supplyOk) begin
            idx       <= '0; // R19
            progAddr  <= startAddr;
            ready_reg <= 1'b0;
            // an unaligned start costs double time per word
            timer     <= (startAddr[SLOT_W-1:0] != '0) ? SLOW_T : WORD_T; // R15
            pst       <= P_BPROG;
          end else if (hostWr) begin
            pst <= P_IDLE;
          end
        end
        P_WPROG: begin
          if (timer == '0) begin
            ready_reg <= 1'b1;
            pst       <= P_IDLE;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        P_BPROG: begin
          if (timer != '0) begin
            timer <= timer - 1'b1;
          end else if (progFault || idx == cntReg) begin
            ready_reg <= 1'b1; // R20
            pst       <= P_IDLE;
          end else begin
            idx      <= idx + 1'b1;
            progAddr <= progAddr + 1'b1;
            timer    <= (startAddr[SLOT_W-1:0] != '0) ? SLOW_T : WORD_T;
          end
        end
        default: pst <= P_IDLE;
      endcase
    end
  end

  // write buffer slots follow the low address bits directly
  always_ff @(posedge mclk) begin
    if (srst) begin
      bufValid <= '0;
    end else if (pst == P_WCOUNT && hostWr) begin
      bufValid <= '0;
    end else if (pst == P_FILL && hostWr && !fillBad) begin
      bufValid[hostAddr[SLOT_W-1:0]] <= 1'b1; // R15
    end
  end

  always_ff @(posedge mclk) begin
    if (pst == P_FILL && hostWr && !fillBad) begin
      bufMem[hostAddr[SLOT_W-1:0]] <= hostData; // R15
    end
  end

  // a failed word leaves the array untouched
  always_ff @(posedge mclk) begin
    if (wordDone && !progFault) begin
      mem[progAddr] <= mem[progAddr] & newWord; // R13
    end
  end

  // deselect during a program waits for the word to finish
  always_ff @(posedge mclk) begin
    if (srst) begin
      standby           <= 1'b0;
      machineReadyFlag  <= 1'b1;
      readConfiguration <= RCFG_RESET;
      burstData         <= '0;
      burstOe           <= 1'b0;
      waitPin           <= 1'b0;
    end else begin
      standby           <= ceNS && ready_reg; // R12
      machineReadyFlag  <= ready_reg;
      readConfiguration <= rcfg_reg;
      burstData         <= rd.dataOut;
      burstOe           <= rd.dataOe;
      waitPin           <= rd.waitOut;
    end
  end

  a_lock_abort: assert property (@(posedge mclk) disable iff (srst) // R10
    pst == P_WDATA && hostWr && lockedHost
      |=> lockErrorFlag && programErrorFlag && pst == P_IDLE && ready_reg)
    else $error("locked program did not abort with both flags");
  a_confirm_seq_err: assert property (@(posedge mclk) disable iff (srst) // R19
    pst == P_CONFIRM && hostWr && cmd != CMD_CONFIRM
      |=> sequenceErrorFlag && programErrorFlag && ready_reg
          ##1 machineReadyFlag)
    else $error("bad confirm did not raise sequence error");
  a_setup_rejected: assert property (@(posedge mclk) disable iff (srst) // R21
    pst == P_IDLE && hostWr && cmd == CMD_BUF_SETUP
      && programErrorFlag && sequenceErrorFlag |=> pst == P_IDLE)
    else $error("buffer setup accepted while errors set");
  a_standby_waits: assert property (@(posedge mclk) disable iff (srst) // R12
    pst == P_WPROG && $past(pst) == P_WPROG |-> !standby)
    else $error("standby entered during word program");
endmodule
`default_nettype wire

// [testbench/fbp_host_model.sv]
// bus master model driving the burst read pins of the flash core
`timescale 1ns/1ps
`default_nettype none
module fbp_host_model #(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  output logic                   flashClk,
  output logic                   advN,
  output logic                   ceN,
  output logic [ADDR_W-1:0]      addrPin
);
  // flash clock stands still outside frames
  initial begin
    flashClk = 1'b0;
    advN = 1'b1;
    ceN = 1'b1;
    addrPin = '0;
  end
  // six mclk per half period leaves room for the four-cycle pin pipeline
  task automatic half(input logic v);
    repeat (6) @(posedge mclk);
    flashClk <= v;
  endtask
  task automatic burst(input logic [ADDR_W-1:0] a, input int edges);
    @(posedge mclk);
    ceN <= 1'b0;
    advN <= 1'b0;
    addrPin <= a;
    half(1'b1);
    half(1'b0);
    advN <= 1'b1;
    // a released address bus must not keep showing the latched value
    addrPin <= ~a;
    repeat (edges) begin
      half(1'b1);
      half(1'b0);
    end
    repeat (6) @(posedge mclk);
    ceN <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [testbench/flash_burst_read_and_program_tb.sv]
// self-checking bench for the flash burst and program core
`timescale 1ns/1ps
`default_nettype none
module flash_burst_read_and_program_tb;
  import fbp_pkg::*;
  logic mclk = 0, srst = 1, cfgLoad = 0, hostWr = 0, supplyPin = 1;
  logic progFault = 0, wDone = 1, expPol = 0, prevOe = 0;
  logic [15:0] cfgValue = 0, hostData = 0, prevData = 0, r;
  logic [7:0] hostAddr = 0;
  logic [3:0] blockLocked = 0;
  logic flashClk, advN, ceN, burstOe, waitPin, machineReadyFlag, standby;
  logic sequenceErrorFlag, programErrorFlag, supplyFaultFlag, lockErrorFlag;
  logic [7:0] addrPin;
  logic [15:0] burstData, readConfiguration;
  logic [15:0] mem [16];
  logic [15:0] expQ [$];
  int fails = 0, compares = 0, seed = 50, fcnt = 0, expLat = 0, cyc = 0;
  fbp_flash_core #(.ADDR_W(8), .BLK_W(6), .PROG_CYCLES(2)) uut (
    .mclk, .srst, .flashClk, .advN, .ceN, .addrPin, .supplyPin, .burstData,
    .burstOe, .waitPin, .cfgLoad, .cfgValue, .readConfiguration, .hostWr,
    .hostAddr, .hostData, .blockLocked, .progFault, .machineReadyFlag,
    .sequenceErrorFlag, .programErrorFlag, .supplyFaultFlag, .lockErrorFlag,
    .standby);
  fbp_host_model #(.ADDR_W(8)) host (.mclk, .flashClk, .advN, .ceN, .addrPin);
  initial forever #2.5 mclk = ~mclk;
  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      $display("unexpected timeout");
      summarize();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    hostWr <= 1'b1;
    hostAddr <= a;
    hostData <= d;
    @(posedge mclk);
    hostWr <= 1'b0;
  endtask
  task automatic flags(input string n, input logic [4:0] e);
    int i;
    repeat (3) @(posedge mclk);
    for (i = 0; i < 200 && machineReadyFlag !== 1'b1; i++) @(posedge mclk);
    chk(n, {10'h0, 1'b1, e}, {10'h0, standby, machineReadyFlag,
        sequenceErrorFlag, programErrorFlag, supplyFaultFlag, lockErrorFlag});
    $display("test %s done", n);
  endtask
  task automatic prog(input logic [7:0] a, input logic [15:0] d);
    wr(a, {8'h0, CMD_WORD_A});
    wr(a, d);
    flags("word program", {1'b1, 1'b0, progFault | ~supplyPin, ~supplyPin,
          1'b0});
  endtask
  task automatic cfg(input logic [15:0] v, input logic [15:0] e);
    @(posedge mclk);
    cfgLoad <= 1'b1;
    cfgValue <= v;
    @(posedge mclk);
    cfgLoad <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("configuration", e, readConfiguration);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] c, input int n);
    int i;
    cfg(c, c);
    expLat = int'(c[14:11]);
    expPol = c[WPOL_POS];
    for (i = 0; i < n; i++) expQ.push_back(mem[(a + i) & (n - 1)]);
    fcnt = -1;
    wDone = 1'b0;
    // with the hold bit every word spans two active edges
    host.burst(a, expLat + (n - 1) * (1 + int'(c[HOLD_POS])));
    chk("words left", 16'h0, 16'(expQ.size()));
    $display("test burst done");
  endtask
  always @(posedge flashClk) fcnt <= fcnt + 1;
  always @(posedge mclk) begin
    if (fcnt == 2 && !wDone) begin
      wDone = 1'b1;
      chk("wait level", {15'h0, expPol}, {15'h0, waitPin});
    end
    if (burstOe === 1'b1 && (!prevOe || burstData !== prevData)) begin
      if (!prevOe) chk("latency", 16'(expLat), 16'(fcnt));
      if (expQ.size() == 0) begin
        fails++;
        $display("unexpected burst word expected none seen %h", burstData);
      end else chk("burst word", expQ.pop_front(), burstData);
    end
    prevOe <= burstOe;
    prevData <= burstData;
  end
  initial begin
    int i;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    chk("configuration", RCFG_RESET, readConfiguration);
    cfg(16'h1C42, RCFG_RESET);
    cfg(16'h5CC2, RCFG_RESET);
    cfg(16'h1CC1, RCFG_RESET);
    for (i = 0; i < 16; i++) begin
      r = 16'($random(seed));
      mem[i] = r;
      prog(8'(i), r);
      r = 16'($random(seed));
      mem[i] = mem[i] & r;
      prog(8'(i), r);
    end
    rd(8'd1, 16'h1CC2, 8);
    rd(8'd14, 16'h28C3, 16);
    rd(8'd3, 16'h1FC2, 8);
    blockLocked <= 4'h2;
    wr(8'd70, {8'h0, CMD_WORD_A});
    wr(8'd70, 16'h0);
    flags("locked", 5'h15);
    wr(8'd0, {8'h0, CMD_CLR_STAT});
    supplyPin <= 1'b0;
    prog(8'd5, 16'h0);
    wr(8'd0, {8'h0, CMD_CLR_STAT});
    supplyPin <= 1'b1;
    progFault <= 1'b1;
    prog(8'd6, 16'h0);
    progFault <= 1'b0;
    wr(8'd0, {8'h0, CMD_CLR_STAT});
    wr(8'd0, {8'h0, CMD_BUF_SETUP});
    wr(8'd0, 16'h0);
    wr(8'd0, 16'h1234);
    wr(8'd0, 16'h00FF);
    flags("bad confirm", 5'h1C);
    wr(8'd0, {8'h0, CMD_BUF_SETUP});
    flags("setup refused", 5'h1C);
    wr(8'd0, {8'h0, CMD_CLR_STAT});
    flags("cleared", 5'h10);
    wr(8'd60, {8'h0, CMD_BUF_SETUP});
    wr(8'd60, 16'h0007);
    wr(8'd60, 16'h0F0F);
    flags("block crossing", 5'h1C);
    summarize();
  end
endmodule
`default_nettype wire
